// [ibm_monitor.sv]
/*
 * Passive two-wire bus trigger monitor with APB registers and a frame
 * report. Assumes scl_in and sda_in are asynchronous bus levels and
 * that pclk is many times faster than the bus clock.
 */
`timescale 1ns/1ns
module ibm_monitor
    import ibm_pkg::*;
#(
    parameter int TS_W = 32
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        scl_in,
    input  wire logic        sda_in,
    output logic             trig_pulse,
    output logic             frame_valid,
    output logic [9:0]       frame_addr,
    output logic             frame_rw,
    output logic [3:0]       frame_bytes,
    output logic [31:0]      frame_data,
    output logic [TS_W-1:0]  frame_time
);
    // ****************************************
    // Line synchronisers
    // ****************************************
    logic [2:0] scl_ff, sda_ff;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            scl_ff <= 3'h7;
            sda_ff <= 3'h7;
        end else begin
            scl_ff <= {scl_ff[1:0], scl_in};
            sda_ff <= {sda_ff[1:0], sda_in};
        end
    end
    logic scl, sda, scl_rise, start_det, stop_det;
    assign scl       = scl_ff[1];
    assign sda       = sda_ff[1];
    assign scl_rise  = scl && !scl_ff[2];
    assign start_det = scl && scl_ff[2] && !sda && sda_ff[2];
    assign stop_det  = scl && scl_ff[2] && sda && !sda_ff[2];

    // ****************************************
    // Configuration and APB slave
    // ****************************************
    ibm_cond_e   cond_ff, nxt_cond;
    ibm_qual_e   qual_ff, nxt_qual;
    logic        a10_ff, dir_ff, m1en_ff, m2en_ff, m1wc_ff, m2wc_ff;
    logic        nxt_a10, nxt_dir, nxt_m1en, nxt_m2en, nxt_m1wc, nxt_m2wc;
    logic [3:0]  cnt_ff, nxt_cnt, wcnt;
    logic [9:0]  taddr_ff, nxt_taddr;
    logic [7:0]  m1_ff, m2_ff, nxt_m1, nxt_m2;
    logic [31:0] prdata_ff, nxt_prdata, rword;
    logic        pready_ff, nxt_pready, pslverr_ff, nxt_pslverr, hit;
    logic [15:0] tcnt_ff, nxt_tcnt;
    ibm_state_e  state_ff, nxt_state;
    logic [9:0]  o_addr_ff;
    logic        o_rw_ff;
    logic [3:0]  o_bytes_ff;
    logic [31:0] o_data_ff;
    logic [TS_W-1:0] o_time_ff;

    always_comb begin
        hit   = 1'b1;
        rword = 32'h0000_0000;
        unique case (paddr)
            OFS_CTRL: begin
                rword[CT_COND+:3] = cond_ff;
                rword[CT_A10]     = a10_ff;
                rword[CT_QUAL+:2] = qual_ff;
                rword[CT_DIR]     = dir_ff;
                rword[CT_M1EN]    = m1en_ff;
                rword[CT_M2EN]    = m2en_ff;
                rword[CT_M1WC]    = m1wc_ff;
                rword[CT_M2WC]    = m2wc_ff;
                rword[CT_CNT+:4]  = cnt_ff;
            end
            OFS_ADDR:  rword[9:0] = taddr_ff;
            OFS_MATCH: rword[15:0] = {m2_ff, m1_ff};
            OFS_STAT: begin
                rword[15:0]    = tcnt_ff;
                rword[ST_BUSY] = (state_ff == S_FRAME);
            end
            OFS_FADDR: begin
                rword[9:0]        = o_addr_ff;
                rword[FA_RW]      = o_rw_ff;
                rword[FA_CNT+:4]  = o_bytes_ff;
            end
            OFS_FDATA: rword = o_data_ff;
            OFS_FTIME: rword[TS_W-1:0] = o_time_ff;
            default:   hit = 1'b0;
        endcase
        // Out-of-range counts are clamped, not rejected
        wcnt = pwdata[CT_CNT+:4];
        if (wcnt < CNT_MIN) begin
            wcnt = CNT_MIN;
        end else if (wcnt > CNT_MAX) begin
            wcnt = CNT_MAX;
        end
        nxt_pready  = psel && penable && !pready_ff;
        nxt_prdata  = nxt_pready ? rword : prdata_ff;
        nxt_pslverr = nxt_pready ? !hit : pslverr_ff;
        nxt_cond  = cond_ff;
        nxt_qual  = qual_ff;
        nxt_a10   = a10_ff;
        nxt_dir   = dir_ff;
        nxt_m1en  = m1en_ff;
        nxt_m2en  = m2en_ff;
        nxt_m1wc  = m1wc_ff;
        nxt_m2wc  = m2wc_ff;
        nxt_cnt   = cnt_ff;
        nxt_taddr = taddr_ff;
        nxt_m1    = m1_ff;
        nxt_m2    = m2_ff;
        // Write commits on the edge that samples pready high
        if (psel && penable && pready_ff && pwrite) begin
            if (paddr == OFS_CTRL) begin
                nxt_cond = ibm_cond_e'(pwdata[CT_COND+:3]);
                nxt_a10  = pwdata[CT_A10];
                nxt_qual = ibm_qual_e'(pwdata[CT_QUAL+:2]);
                nxt_dir  = pwdata[CT_DIR];
                nxt_m1en = pwdata[CT_M1EN];
                nxt_m2en = pwdata[CT_M2EN];
                nxt_m1wc = pwdata[CT_M1WC];
                nxt_m2wc = pwdata[CT_M2WC];
                nxt_cnt  = wcnt;
            end
            if (paddr == OFS_ADDR) begin
                nxt_taddr = pwdata[9:0];
            end
            if (paddr == OFS_MATCH) begin
                nxt_m1 = pwdata[7:0];
                nxt_m2 = pwdata[MT_M2+:8];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cond_ff    <= C_START;
            qual_ff    <= Q_EQ;
            a10_ff     <= 1'b0;
            dir_ff     <= 1'b0;
            m1en_ff    <= 1'b0;
            m2en_ff    <= 1'b0;
            m1wc_ff    <= 1'b0;
            m2wc_ff    <= 1'b0;
            cnt_ff     <= CNT_MIN;
            taddr_ff   <= 10'h000;
            m1_ff      <= 8'h00;
            m2_ff      <= 8'h00;
            prdata_ff  <= 32'h0000_0000;
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
        end else begin
            cond_ff    <= nxt_cond;
            qual_ff    <= nxt_qual;
            a10_ff     <= nxt_a10;
            dir_ff     <= nxt_dir;
            m1en_ff    <= nxt_m1en;
            m2en_ff    <= nxt_m2en;
            m1wc_ff    <= nxt_m1wc;
            m2wc_ff    <= nxt_m2wc;
            cnt_ff     <= nxt_cnt;
            taddr_ff   <= nxt_taddr;
            m1_ff      <= nxt_m1;
            m2_ff      <= nxt_m2;
            prdata_ff  <= nxt_prdata;
            pready_ff  <= nxt_pready;
            pslverr_ff <= nxt_pslverr;
        end
    end

    // ****************************************
    // Frame decoder and trigger
    // ****************************************
    logic [3:0]  bit_ff, nxt_bit, byte_ff, nxt_byte, nb_ff, nxt_nb;
    logic [7:0]  sr_ff, nxt_sr;
    logic        is10_ff, nxt_is10, rw_ff, nxt_rw, m1p_ff, nxt_m1p;
    logic        arm_ff, nxt_arm, trig_ff, nxt_trig, fval_ff, nxt_fval;
    logic [9:0]  fa_ff, nxt_fa;
    logic [31:0] fd_ff, nxt_fd;
    logic [TS_W-1:0] now_ff, tat_ff, fst_ff, nxt_tat, nxt_fst;
    logic [9:0]  nxt_o_addr;
    logic        nxt_o_rw;
    logic [3:0]  nxt_o_bytes;
    logic [31:0] nxt_o_data;
    logic [TS_W-1:0] nxt_o_time;
    logic        fire, ack_slot, addr_hit, m1_hit, m2_hit, d_hit, q_hit;
    logic        in_frame;

    assign in_frame = (state_ff == S_FRAME);
    assign ack_slot = scl_rise && in_frame && !start_det && !stop_det
                      && (bit_ff == ACK_SLOT);
    assign addr_hit = (cond_ff == C_ADDR7)
                      ? (!is10_ff && fa_ff == (taddr_ff & MASK7))
                      : (is10_ff && fa_ff == taddr_ff);
    assign m1_hit   = m1wc_ff || sr_ff == m1_ff;
    assign m2_hit   = m2wc_ff || sr_ff == m2_ff;

    always_comb begin
        // No match byte enabled: any data byte matches
        d_hit = 1'b1;
        if (m1en_ff && m2en_ff) begin
            d_hit = m1p_ff && m2_hit;
        end else if (m1en_ff) begin
            d_hit = m1_hit;
        end else if (m2en_ff) begin
            d_hit = m2_hit;
        end
        unique case (qual_ff)
            Q_LT:    q_hit = sr_ff < m1_ff;
            Q_GT:    q_hit = sr_ff > m1_ff;
            default: q_hit = sr_ff == m1_ff;
        endcase
    end

    always_comb begin
        fire      = 1'b0;
        nxt_state = state_ff;
        nxt_bit   = bit_ff;
        nxt_byte  = byte_ff;
        nxt_nb    = nb_ff;
        nxt_sr    = sr_ff;
        nxt_is10  = is10_ff;
        nxt_rw    = rw_ff;
        nxt_m1p   = m1p_ff;
        nxt_arm   = arm_ff;
        nxt_fa    = fa_ff;
        nxt_fd    = fd_ff;
        nxt_fst   = fst_ff;
        nxt_fval  = 1'b0;
        nxt_o_addr  = o_addr_ff;
        nxt_o_rw    = o_rw_ff;
        nxt_o_bytes = o_bytes_ff;
        nxt_o_data  = o_data_ff;
        nxt_o_time  = o_time_ff;
        if ((start_det || stop_det) && in_frame && byte_ff != 4'h0) begin
            nxt_fval    = 1'b1;
            nxt_o_addr  = fa_ff;
            nxt_o_rw    = rw_ff;
            nxt_o_bytes = nb_ff;
            nxt_o_data  = fd_ff;
            nxt_o_time  = fst_ff - tat_ff;
        end
        if (start_det) begin
            fire = (cond_ff == C_START)
                   || (cond_ff == C_RESTART && in_frame);
            nxt_state = S_FRAME;
            nxt_bit   = 4'h0;
            nxt_byte  = 4'h0;
            nxt_nb    = 4'h0;
            nxt_m1p   = 1'b0;
            nxt_fd    = 32'h0000_0000;
            nxt_fst   = now_ff;
        end else if (stop_det) begin
            fire = (cond_ff == C_STOP)
                   || (cond_ff == C_COUNT && in_frame
                       && nb_ff == cnt_ff && is10_ff == a10_ff);
            nxt_state = S_IDLE;
            nxt_arm   = 1'b0;
        end else if (scl_rise && in_frame) begin
            if (bit_ff != ACK_SLOT) begin
                nxt_sr  = {sr_ff[6:0], sda};
                nxt_bit = bit_ff + 4'h1;
            end else begin
                nxt_bit  = 4'h0;
                nxt_byte = (byte_ff == 4'hF) ? byte_ff : byte_ff + 4'h1;
                if (cond_ff == C_NOACK && sda) begin
                    fire = 1'b1;
                end
                if (byte_ff == 4'h0) begin
                    nxt_is10 = a10_ff && sr_ff[7:3] == HDR10;
                    nxt_fa   = nxt_is10 ? {sr_ff[2:1], 8'h00}
                                        : {3'h0, sr_ff[7:1]};
                    nxt_rw   = sr_ff[0];
                    if (sr_ff[7:4] == MEM_NIB && sr_ff[0] && !sda) begin
                        nxt_arm = 1'b1;
                    end
                end else if (is10_ff && byte_ff == 4'h1) begin
                    nxt_fa = {fa_ff[9:8], sr_ff};
                end else begin
                    nxt_nb  = (nb_ff == 4'hF) ? nb_ff : nb_ff + 4'h1;
                    nxt_fd  = {fd_ff[23:0], sr_ff};
                    nxt_m1p = m1en_ff && m1_hit;
                    if ((cond_ff == C_ADDR7 || cond_ff == C_ADDR10)
                        && addr_hit && d_hit
                        && rw_ff == dir_ff) begin
                        fire = 1'b1;
                    end
                    if (cond_ff == C_MEM && arm_ff && q_hit) begin
                        fire = 1'b1;
                    end
                end
            end
        end
        nxt_trig = fire;
        nxt_tat  = fire ? now_ff : tat_ff;
        nxt_tcnt = fire ? tcnt_ff + 16'h0001 : tcnt_ff;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_ff   <= S_IDLE;
            bit_ff     <= 4'h0;
            byte_ff    <= 4'h0;
            nb_ff      <= 4'h0;
            sr_ff      <= 8'h00;
            is10_ff    <= 1'b0;
            rw_ff      <= 1'b0;
            m1p_ff     <= 1'b0;
            arm_ff     <= 1'b0;
            fa_ff      <= 10'h000;
            fd_ff      <= 32'h0000_0000;
            now_ff     <= '0;
            tat_ff     <= '0;
            fst_ff     <= '0;
            trig_ff    <= 1'b0;
            fval_ff    <= 1'b0;
            tcnt_ff    <= 16'h0000;
            o_addr_ff  <= 10'h000;
            o_rw_ff    <= 1'b0;
            o_bytes_ff <= 4'h0;
            o_data_ff  <= 32'h0000_0000;
            o_time_ff  <= '0;
        end else begin
            state_ff   <= nxt_state;
            bit_ff     <= nxt_bit;
            byte_ff    <= nxt_byte;
            nb_ff      <= nxt_nb;
            sr_ff      <= nxt_sr;
            is10_ff    <= nxt_is10;
            rw_ff      <= nxt_rw;
            m1p_ff     <= nxt_m1p;
            arm_ff     <= nxt_arm;
            fa_ff      <= nxt_fa;
            fd_ff      <= nxt_fd;
            // Free-running; wrap gives signed offsets
            now_ff     <= now_ff + 1'b1;
            tat_ff     <= nxt_tat;
            fst_ff     <= nxt_fst;
            trig_ff    <= nxt_trig;
            fval_ff    <= nxt_fval;
            tcnt_ff    <= nxt_tcnt;
            o_addr_ff  <= nxt_o_addr;
            o_rw_ff    <= nxt_o_rw;
            o_bytes_ff <= nxt_o_bytes;
            o_data_ff  <= nxt_o_data;
            o_time_ff  <= nxt_o_time;
        end
    end

    assign prdata      = prdata_ff;
    assign pready      = pready_ff;
    assign pslverr     = pslverr_ff;
    assign trig_pulse  = trig_ff;
    assign frame_valid = fval_ff;
    assign frame_addr  = o_addr_ff;
    assign frame_rw    = o_rw_ff;
    assign frame_bytes = o_bytes_ff;
    assign frame_data  = o_data_ff;
    assign frame_time  = o_time_ff;

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    start_trig_a: assert property (
        cond_ff == C_START && start_det |=> trig_pulse)
        else $error("start not triggered");
    restart_as_start_a: assert property (
        cond_ff == C_START && start_det && in_frame
        |=> trig_pulse && state_ff == S_FRAME && byte_ff == 4'h0)
        else $error("repeated start not treated as start");
    stop_trig_a: assert property (
        cond_ff == C_STOP && stop_det |=> trig_pulse && !in_frame)
        else $error("stop not triggered");
    restart_trig_a: assert property (
        cond_ff == C_RESTART && trig_pulse
        |-> $past(start_det) && $past(in_frame))
        else $error("restart trigger without open frame");
    noack_trig_a: assert property (
        cond_ff == C_NOACK && ack_slot && sda |=> trig_pulse)
        else $error("missing ack not triggered");
    mem_gate_a: assert property (
        cond_ff == C_MEM && trig_pulse |-> $past(arm_ff))
        else $error("memory trigger without control byte");
    addr7_gate_a: assert property (
        cond_ff == C_ADDR7 && trig_pulse
        |-> $past(addr_hit) && !$past(is10_ff))
        else $error("short address trigger without match");
    addr10_gate_a: assert property (
        cond_ff == C_ADDR10 && trig_pulse
        |-> $past(addr_hit) && $past(is10_ff))
        else $error("long address trigger without match");
    dir_gate_a: assert property (
        (cond_ff == C_ADDR7 || cond_ff == C_ADDR10) && trig_pulse
        |-> $past(rw_ff) == dir_ff)
        else $error("trigger on wrong direction");
    count_trig_a: assert property (
        cond_ff == C_COUNT && trig_pulse
        |-> $past(stop_det) && $past(nb_ff) == cnt_ff)
        else $error("byte count trigger mismatch");
    count_range_a: assert property (
        cnt_ff >= CNT_MIN && cnt_ff <= CNT_MAX)
        else $error("byte count out of range");
    trig_pulse_a: assert property (
        trig_pulse |=> !trig_pulse)
        else $error("trigger longer than one cycle");
    apb_answer_a: assert property (
        psel && penable && !pready |=> pready ##1 !pready)
        else $error("apb answer timing wrong");
endmodule

// [ibm_pkg.sv]
/*
 * Constants, register map and types for the two-wire bus trigger monitor.
 * Assumes an APB slave port with 32-bit data and byte addresses.
 */
package ibm_pkg;
    // ****************************************
    // Register map
    // ****************************************
    localparam logic [7:0] OFS_CTRL  = 8'h00;
    localparam logic [7:0] OFS_ADDR  = 8'h04;
    localparam logic [7:0] OFS_MATCH = 8'h08;
    localparam logic [7:0] OFS_STAT  = 8'h0C;
    localparam logic [7:0] OFS_FADDR = 8'h10;
    localparam logic [7:0] OFS_FDATA = 8'h14;
    localparam logic [7:0] OFS_FTIME = 8'h18;
    // CTRL, MATCH, STAT and FADDR fields
    localparam int CT_COND = 0;
    localparam int CT_A10  = 3;
    localparam int CT_QUAL = 4;
    localparam int CT_DIR  = 6;
    localparam int CT_M1EN = 7;
    localparam int CT_M2EN = 8;
    localparam int CT_M1WC = 9;
    localparam int CT_M2WC = 10;
    localparam int CT_CNT  = 11;
    localparam int MT_M2   = 8;
    localparam int ST_BUSY = 16;
    localparam int FA_RW   = 10;
    localparam int FA_CNT  = 12;
    // ****************************************
    // Values
    // ****************************************
    localparam logic [3:0] CNT_MIN  = 4'h1;
    localparam logic [3:0] CNT_MAX  = 4'hC;
    localparam logic [3:0] ACK_SLOT = 4'h8;
    localparam logic [3:0] MEM_NIB  = 4'hA;
    localparam logic [4:0] HDR10    = 5'h1E;
    localparam logic [9:0] MASK7    = 10'h07F;
    typedef enum logic [2:0] {
        C_START = 3'h0, C_STOP = 3'h1, C_RESTART = 3'h2, C_NOACK = 3'h3,
        C_MEM = 3'h4, C_ADDR7 = 3'h5, C_ADDR10 = 3'h6, C_COUNT = 3'h7
    } ibm_cond_e;
    typedef enum logic [1:0] {
        Q_EQ = 2'h0, Q_LT = 2'h1, Q_GT = 2'h2, Q_RSV = 2'h3
    } ibm_qual_e;
    typedef enum logic [1:0] {
        S_IDLE = 2'b01, S_FRAME = 2'b10
    } ibm_state_e;
endpackage

// [ibm_bus_model.sv]
/*
 * Behavioural controller and target on the monitored two-wire bus.
 * Assumes clk is the monitor clock; lines idle high through pull-ups.
 */
`timescale 1ns/1ns
module ibm_bus_model (
    input  wire logic clk,
    output logic      scl,
    output logic      sda
);
    // ****************************************
    // Bus sequences
    // ****************************************
    // Released lines float to the pull-up level
    initial begin
        scl = 1'b1;
        sda = 1'b1;
    end
    task automatic wt(input int n);
        repeat (n) @(posedge clk);
    endtask
    // Data moves only while the clock is low; a bit spans 80 ns
    task automatic send_bit(input logic v);
        sda <= v;
        wt(2);
        scl <= 1'b1;
        wt(4);
        scl <= 1'b0;
        wt(2);
    endtask
    task automatic start_cond();
        sda <= 1'b1;
        wt(2);
        scl <= 1'b1;
        wt(4);
        sda <= 1'b0;
        wt(4);
        scl <= 1'b0;
        wt(2);
    endtask
    task automatic stop_cond();
        sda <= 1'b0;
        wt(2);
        scl <= 1'b1;
        wt(4);
        sda <= 1'b1;
        wt(4);
    endtask
    // Ninth bit is the acknowledge slot; high means refused
    task automatic send_byte(input logic [7:0] b, input logic nak);
        for (int i = 7; i >= 0; i--) begin
            send_bit(b[i]);
        end
        send_bit(nak);
    endtask
endmodule

// [tb.sv]
/*
 * Self-checking bench for the two-wire bus trigger monitor.
 * Assumes the bus model drives the lines and APB reaches the registers.
 */
`timescale 1ns/1ns
module tb;
    import ibm_pkg::*;
    // ****************************************
    // Signals
    // ****************************************
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, frame_data, frame_time, rd;
    logic        scl, sda, trig_pulse, frame_valid, frame_rw, er;
    logic [9:0]  frame_addr;
    logic [3:0]  frame_bytes;
    int          err_total, samples_checked, ntrig, nfv;

    ibm_monitor u_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .scl_in(scl), .sda_in(sda),
        .trig_pulse(trig_pulse), .frame_valid(frame_valid),
        .frame_addr(frame_addr), .frame_rw(frame_rw),
        .frame_bytes(frame_bytes), .frame_data(frame_data),
        .frame_time(frame_time)
    );
    ibm_bus_model u_bus (.clk(pclk), .scl(scl), .sda(sda));

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        if (trig_pulse === 1'b1) begin
            ntrig <= ntrig + 1;
        end
        if (frame_valid === 1'b1) begin
            nfv <= nfv + 1;
        end
    end
    // ****************************************
    // Tasks
    // ****************************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    // Flags: bit 0 refuses the last data byte, bit 1 adds a restart
    task automatic run(input logic [31:0] c, ad, mt,
                       input logic [7:0] a, d0, d1,
                       input logic [1:0] f, input int ex);
        int n0;
        apb(1'b1, OFS_CTRL, c);
        apb(1'b1, OFS_ADDR, ad);
        apb(1'b1, OFS_MATCH, mt);
        n0 = ntrig;
        u_bus.start_cond();
        u_bus.send_byte(a, 1'b0);
        u_bus.send_byte(d0, 1'b0);
        u_bus.send_byte(d1, f[0]);
        if (f[1]) begin
            u_bus.start_cond();
            u_bus.send_byte(a, 1'b0);
        end
        u_bus.stop_cond();
        repeat (8) @(posedge pclk);
        chk(32'(ntrig - n0), 32'(ex));
        $display("test cond %0d done", c[2:0]);
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // ****************************************
    // Tests
    // ****************************************
    // About 5000 cycles expected; four times that means a hang
    initial begin
        repeat (20000) @(posedge pclk);
        err_total++;
        print_verdict();
    end
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        repeat (3) @(posedge pclk);
        apb(1'b0, OFS_CTRL, 32'h0);
        chk(rd, 32'h0000_0800);
        apb(1'b0, 8'h1C, 32'h0);
        chk({rd[30:0], er}, 32'h0000_0001);
        apb(1'b1, OFS_CTRL, 32'h0000_7800);
        apb(1'b0, OFS_CTRL, 32'h0);
        chk(rd, 32'h0000_6000);
        apb(1'b1, OFS_ADDR, 32'h0000_03FF);
        apb(1'b0, OFS_ADDR, 32'h0);
        chk(rd, 32'h0000_03FF);
        $display("test registers done");
        run(32'h0, 32'h0, 32'h0, 8'hA0, 8'h12, 8'h34, 2'h2, 2);
        // Both frames open at their own trigger: zero offset
        chk(32'(nfv), 32'h0000_0002);
        chk(frame_time, 32'h0000_0000);
        run(32'h1, 32'h0, 32'h0, 8'hA0, 8'h12, 8'h34, 2'h0, 1);
        run(32'h2, 32'h0, 32'h0, 8'hA0, 8'h12, 8'h34, 2'h2, 1);
        run(32'h2, 32'h0, 32'h0, 8'hA0, 8'h12, 8'h34, 2'h0, 0);
        run(32'h3, 32'h0, 32'h0, 8'hA0, 8'h12, 8'h34, 2'h1, 1);
        run(32'h3, 32'h0, 32'h0, 8'hA0, 8'h12, 8'h34, 2'h0, 0);
        run(32'hA4, 32'h0, 32'h20, 8'hA1, 8'h10, 8'h30, 2'h0, 1);
        run(32'h94, 32'h0, 32'h20, 8'hA1, 8'h10, 8'h30, 2'h0, 1);
        run(32'h84, 32'h0, 32'h30, 8'hA1, 8'h10, 8'h30, 2'h0, 1);
        run(32'hB4, 32'h0, 32'h30, 8'hA1, 8'h10, 8'h30, 2'h0, 1);
        run(32'hA4, 32'h0, 32'h20, 8'hA0, 8'h10, 8'h30, 2'h0, 0);
        run(32'h185, 32'h50, 32'h3412, 8'hA0, 8'h12, 8'h34, 2'h0, 1);
        apb(1'b0, OFS_FADDR, 32'h0);
        chk(rd, 32'h0000_2050);
        apb(1'b0, OFS_FDATA, 32'h0);
        chk(rd, 32'h0000_1234);
        chk({21'h0, frame_rw, frame_addr}, 32'h0000_0050);
        chk(frame_data, 32'h0000_1234);
        chk({28'h0, frame_bytes}, 32'h0000_0002);
        // Trigger came after frame start, so the offset is negative
        chk({31'h0, frame_time[31]}, 32'h0000_0001);
        run(32'h185, 32'h50, 32'h3412, 8'hA0, 8'h12, 8'h35, 2'h0, 0);
        run(32'h585, 32'h50, 32'h3412, 8'hA0, 8'h12, 8'h35, 2'h0, 1);
        run(32'h105, 32'h50, 32'h3400, 8'hA0, 8'h12, 8'h34, 2'h0, 1);
        run(32'h1C5, 32'h50, 32'h3412, 8'hA0, 8'h12, 8'h34, 2'h0, 0);
        run(32'h185, 32'h51, 32'h3412, 8'hA0, 8'h12, 8'h34, 2'h0, 0);
        run(32'h8E, 32'h2A5, 32'h56, 8'hF4, 8'hA5, 8'h56, 2'h0, 1);
        run(32'h1007, 32'h0, 32'h0, 8'hA0, 8'h12, 8'h34, 2'h0, 1);
        run(32'h1807, 32'h0, 32'h0, 8'hA0, 8'h12, 8'h34, 2'h0, 0);
        apb(1'b0, OFS_STAT, 32'h0);
        chk(rd & 32'h0001_FFFF, 32'(ntrig));
        print_verdict();
    end
endmodule
